// ==== hw/line_conditioner.v ====
// Purpose: resynchronise remote lines and flag their rising edges
// Assumes: lines may change at any time relative to sys_clk
// Notes: rise is a one-cycle pulse, level is the settled value
`timescale 1ns/1ps
`default_nettype none

module line_conditioner (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // Lines
  input wire [23:0] lines,
  output wire [23:0] level,
  output wire [23:0] rise
);

  reg [23:0] sync_a;
  reg [23:0] sync_b;
  reg [23:0] prev;

  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_line
      // --------------------------------
      // Two-stage synchroniser and edge
      // --------------------------------
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else if (ce) begin
          sync_a[g] <= lines[g];
          sync_b[g] <= sync_a[g];
          prev[g] <= sync_b[g];
        end
      end
      assign rise[g] = sync_b[g] & ~prev[g];
      assign level[g] = sync_b[g];
    end
  endgenerate

endmodule // line_conditioner

`default_nettype wire

// ==== hw/remote_input_command_gate.v ====
// Purpose: turn remote input lines into controller actions
// Assumes: controller status inputs are synchronous to sys_clk
// Notes: map registers pick which line drives each function
//
// Overview of operation
// - Inputs other than forced low power honoured only when assigned and remote source; flag remote mode.
// - Remote function usable only with virtual I/O enabled.
// - All inputs but program select and forced low power act on their rising edge.
// - While error is on only reset and forced low power are accepted.
// - Start needs ready, no error/estop/guard, pause and stop off.
// - Select bits 1,2,4 default to lines 1,2,3; higher unassigned.
// - Stop, default line 4, halts all tasks and commands.
// - Pause, default line 5, accepted only while running.
// - Continue, default line 6, needs paused, pause and stop off.
// - Reset, default line 7, clears estop and error when ready.
// - Forced low power honoured at any time, even outside remote.
// - Defaults occupy lines 0 to 7; mapping is reconfigurable.
// - Shutdown, unassigned by default, terminates the system.
// - Six select bits form a number 0 to 63.
// - Remote mode active gates every function not accepted anytime.
`timescale 1ns/1ps
`default_nettype none
`include "remote_gate_defs.vh"

module remote_input_command_gate (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // Remote input lines
  input wire [23:0] remote_lines,
  // Controller status
  input wire ready,
  input wire running,
  input wire paused,
  input wire error,
  input wire emergency_stop_active,
  input wire guard_open_active,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rd_data,
  // Actions
  output reg start_pulse,
  output reg [5:0] program_select_bits,
  output reg stop_pulse,
  output reg pause_pulse,
  output reg continue_pulse,
  output reg reset_pulse,
  output reg shutdown_pulse,
  output reg forced_low_power,
  output reg remote_mode_active,
  output reg irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Value of the line a map entry points at; out-of-range reads low
  function pick;
    input [23:0] v;
    input [5:0] m;
    begin
      if (m[`RG_MAP_EN] && (m[4:0] < 5'd24))
        pick = v[m[4:0]];
      else
        pick = 1'b0;
    end
  endfunction

  // Reset contents of the map table
  function [5:0] map_default;
    input integer f;
    begin
      case (f)
        `RG_F_START: map_default = `RG_MAP_START;
        `RG_F_STOP: map_default = `RG_MAP_STOP;
        `RG_F_PAUSE: map_default = `RG_MAP_PAUSE;
        `RG_F_CONT: map_default = `RG_MAP_CONT;
        `RG_F_RESET: map_default = `RG_MAP_RESET;
        `RG_F_SEL0: map_default = `RG_MAP_SEL1;
        `RG_F_SEL0 + 1: map_default = `RG_MAP_SEL2;
        `RG_F_SEL0 + 2: map_default = `RG_MAP_SEL4;
        default: map_default = `RG_MAP_NONE;
      endcase
    end
  endfunction

  // Map table slot an address selects; bit 4 flags a hit. Word
  // aligned only, so a stray byte address never remaps a function.
  function [4:0] map_slot;
    input [7:0] a;
    begin
      if (a >= `RG_MAP_BASE && a < `RG_MAP_BASE + 8'h34 &&
          a[1:0] == 2'b00)
        map_slot = {1'b1, a[5:2] - 4'h4};
      else
        map_slot = 5'h00;
    end
  endfunction

  // ----------------------------------------
  // Line conditioning
  // ----------------------------------------
  wire [23:0] lvl;
  wire [23:0] rise;

  line_conditioner u_cond (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .lines(remote_lines),
    .level(lvl),
    .rise(rise)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [2:0] ctrl;
  reg [5:0] fmap [0:12];
  reg [6:0] int_stat;
  reg [6:0] int_mask;
  integer i;

  // ----------------------------------------
  // Per-function trigger and level
  // ----------------------------------------
  wire trig_start;
  wire trig_stop;
  wire trig_pause;
  wire trig_cont;
  wire trig_reset;
  wire trig_shut;
  wire lvl_pause;
  wire lvl_stop;
  wire lvl_lowpwr;
  wire [5:0] sel_now;

  assign trig_start = pick(rise, fmap[`RG_F_START]);
  assign trig_stop = pick(rise, fmap[`RG_F_STOP]);
  assign trig_pause = pick(rise, fmap[`RG_F_PAUSE]);
  assign trig_cont = pick(rise, fmap[`RG_F_CONT]);
  assign trig_reset = pick(rise, fmap[`RG_F_RESET]);
  assign trig_shut = pick(rise, fmap[`RG_F_SHUTDOWN]);
  assign lvl_pause = pick(lvl, fmap[`RG_F_PAUSE]);
  assign lvl_stop = pick(lvl, fmap[`RG_F_STOP]);
  assign lvl_lowpwr = pick(lvl, fmap[`RG_F_LOWPWR]);

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sel
      assign sel_now[g] = pick(lvl, fmap[`RG_F_SEL0 + g]);
    end
  endgenerate

  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  wire mode_ok;
  wire ok_start;
  wire ok_stop;
  wire ok_pause;
  wire ok_cont;
  wire ok_reset;
  wire ok_shut;
  wire any_trig;
  wire any_ok;
  wire start_clear;
  wire lines_clear;

  assign mode_ok = ctrl[`RG_CTRL_ASSIGNED] & ctrl[`RG_CTRL_SRC_REMOTE] &
                   ctrl[`RG_CTRL_VIO_EN];

  assign start_clear = ready & ~error & ~emergency_stop_active &
                       ~guard_open_active;
  // Held pause or stop lines veto both start and continue
  assign lines_clear = ~lvl_pause & ~lvl_stop;
  assign ok_start = trig_start & remote_mode_active & start_clear &
                    lines_clear;
  assign ok_stop = trig_stop & remote_mode_active & ~error;
  assign ok_pause = trig_pause & remote_mode_active & ~error & running;
  assign ok_cont = trig_cont & remote_mode_active & ~error & paused &
                   lines_clear;
  assign ok_reset = trig_reset & remote_mode_active & ready;
  assign ok_shut = trig_shut & remote_mode_active & ~error;

  // flag triggers dropped when nothing was accepted
  assign any_trig = trig_start |
                    trig_stop |
                    trig_pause |
                    trig_cont |
                    trig_reset |
                    trig_shut;
  assign any_ok = ok_start |
                  ok_stop |
                  ok_pause |
                  ok_cont |
                  ok_reset |
                  ok_shut;

  // ----------------------------------------
  // Action outputs
  // ----------------------------------------
  // Triggers that miss their conditions are simply dropped, so a
  // sequencer must raise the line again once the state allows it.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_pulse <= 1'b0;
      program_select_bits <= 6'h00;
      stop_pulse <= 1'b0;
      pause_pulse <= 1'b0;
      continue_pulse <= 1'b0;
      reset_pulse <= 1'b0;
      shutdown_pulse <= 1'b0;
      forced_low_power <= 1'b0;
      remote_mode_active <= 1'b0;
    end else if (ce) begin
      start_pulse <= ok_start;
      stop_pulse <= ok_stop;
      pause_pulse <= ok_pause;
      continue_pulse <= ok_cont;
      reset_pulse <= ok_reset;
      shutdown_pulse <= ok_shut;
      if (ok_start) begin
        program_select_bits <= sel_now;
      end
      forced_low_power <= lvl_lowpwr;
      remote_mode_active <= mode_ok;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire [6:0] events;
  wire [6:0] clr_bits;
  wire [6:0] next_int_stat;
  wire [4:0] wr_slot;

  assign events = {any_trig & ~any_ok,
                   ok_shut,
                   ok_reset,
                   ok_cont,
                   ok_pause,
                   ok_stop,
                   ok_start};
  assign clr_bits = (wr_en && addr == `RG_INT_STAT_ADDR) ?
                    wr_data[6:0] : 7'h00;
  // A new event beats a clear in the same cycle, so none is lost
  assign next_int_stat = (int_stat & ~clr_bits) | events;
  assign wr_slot = map_slot(addr);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `RG_CTRL_RESET;
      int_mask <= 7'h00;
      int_stat <= 7'h00;
      for (i = 0; i < 13; i = i + 1) begin
        fmap[i] <= map_default(i);
      end
    end else if (ce) begin
      int_stat <= next_int_stat;
      if (wr_en) begin
        if (addr == `RG_CTRL_ADDR) begin
          ctrl <= wr_data[2:0];
        end
        if (addr == `RG_INT_MASK_ADDR) begin
          int_mask <= wr_data[6:0];
        end
        if (wr_slot[4]) begin
          fmap[wr_slot[3:0]] <= wr_data[5:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Read port and interrupt
  // ----------------------------------------
  reg [31:0] next_rd_data;
  reg [4:0] rd_slot;

  always @* begin
    next_rd_data = 32'h00000000;
    rd_slot = 5'h00;
    case (addr)
      `RG_CTRL_ADDR: next_rd_data = {29'h0, ctrl};
      // Live status levels, not latched, so a read shows this cycle; program_select_bits hold the value latched at the last accepted start
      `RG_STAT_ADDR: next_rd_data = {16'h0,
                                      program_select_bits,
                                      forced_low_power,
                                      remote_mode_active,
                                      2'h0,
                                      guard_open_active,
                                      emergency_stop_active,
                                      error,
                                      paused,
                                      running,
                                      ready};
      `RG_INT_STAT_ADDR: next_rd_data = {25'h0, int_stat};
      `RG_INT_MASK_ADDR: next_rd_data = {25'h0, int_mask};
      default: begin
        // Unmapped addresses read as zero
        rd_slot = map_slot(addr);
        if (rd_slot[4]) begin
          next_rd_data = {26'h0, fmap[rd_slot[3:0]]};
        end
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h00000000;
      irq <= 1'b0;
    end else if (ce) begin
      // Data stand in the cycle after each rd_en cycle, zero otherwise
      rd_data <= rd_en ? next_rd_data : 32'h00000000;
      irq <= |(next_int_stat & int_mask);
    end
  end

endmodule // remote_input_command_gate

`default_nettype wire

// ==== include/remote_gate_defs.vh ====
// Purpose: constants for the remote input command gate
// Assumes: 100 MHz sys_clk, 8-bit byte address, 32-bit register data
// Notes: map entries hold {assigned, line[4:0]}
`ifndef REMOTE_GATE_DEFS_VH
`define REMOTE_GATE_DEFS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define RG_LINES 24
`define RG_FUNCS 13
`define RG_EVENTS 7

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RG_CTRL_ADDR 8'h00
`define RG_STAT_ADDR 8'h04
`define RG_INT_STAT_ADDR 8'h08
`define RG_INT_MASK_ADDR 8'h0c
`define RG_MAP_BASE 8'h10

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define RG_CTRL_ASSIGNED 0
`define RG_CTRL_SRC_REMOTE 1
`define RG_CTRL_VIO_EN 2
`define RG_CTRL_RESET 3'h0

// ----------------------------------------
// Function slots in the map table
// ----------------------------------------
`define RG_F_START 0
`define RG_F_STOP 1
`define RG_F_PAUSE 2
`define RG_F_CONT 3
`define RG_F_RESET 4
`define RG_F_SHUTDOWN 5
`define RG_F_LOWPWR 6
`define RG_F_SEL0 7

// ----------------------------------------
// Map entry layout and default lines
// ----------------------------------------
`define RG_MAP_EN 5
`define RG_MAP_NONE 6'h00
`define RG_MAP_START 6'h20
`define RG_MAP_SEL1 6'h21
`define RG_MAP_SEL2 6'h22
`define RG_MAP_SEL4 6'h23
`define RG_MAP_STOP 6'h24
`define RG_MAP_PAUSE 6'h25
`define RG_MAP_CONT 6'h26
`define RG_MAP_RESET 6'h27

// ----------------------------------------
// Event bits (interrupt status and mask)
// ----------------------------------------
`define RG_EV_START 0
`define RG_EV_STOP 1
`define RG_EV_PAUSE 2
`define RG_EV_CONT 3
`define RG_EV_RESET 4
`define RG_EV_SHUTDOWN 5
`define RG_EV_REJECT 6

`endif

// ==== verif/remote_gate_sva.sv ====
// Purpose: port-level checks on the remote input command gate
// Assumes: single sys_clk domain, rst asynchronous active high
// Notes: pulses trail the status they were judged on by one sample
`timescale 1ns/1ps
`default_nettype none
module remote_gate_sva (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Status and bus
  input wire logic ready,
  input wire logic running,
  input wire logic paused,
  input wire logic error,
  input wire logic emergency_stop_active,
  input wire logic guard_open_active,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Actions
  input wire logic start_pulse,
  input wire logic [5:0] program_select_bits,
  input wire logic stop_pulse,
  input wire logic pause_pulse,
  input wire logic continue_pulse,
  input wire logic reset_pulse,
  input wire logic remote_mode_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ctrl_on;
    wr_en && ce && addr == 8'h00 && wr_data[2:0] == 3'h7;
  endsequence
  sequence s_mode_off;
    !remote_mode_active ##1 !remote_mode_active ##1 !remote_mode_active;
  endsequence
  chk_mode_on_write: assert property (
    s_ctrl_on |-> ##[1:2] remote_mode_active)
    else $error("remote mode not raised");
  chk_mode_off_quiet: assert property (
    s_mode_off |-> !(start_pulse || stop_pulse || pause_pulse ||
    continue_pulse))
    else $error("action while remote mode off");
  chk_start_cond: assert property (
    start_pulse |-> $past(ready && !error && !emergency_stop_active &&
    !guard_open_active))
    else $error("start accepted without its conditions");
  chk_stop_cond: assert property (
    stop_pulse |-> $past(!error))
    else $error("stop accepted during error");
  chk_pause_cond: assert property (
    pause_pulse |-> $past(running && !error))
    else $error("pause accepted while not running");
  chk_cont_cond: assert property (
    continue_pulse |-> $past(paused && !error))
    else $error("continue accepted while not paused");
  chk_reset_cond: assert property (
    reset_pulse |-> $past(ready))
    else $error("reset accepted while not ready");
  chk_pulse_single: assert property (
    start_pulse |=> !start_pulse)
    else $error("start pulse longer than one cycle");
  chk_sel_hold: assert property (
    !start_pulse |-> $stable(program_select_bits))
    else $error("select bits moved without start");
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside its cycle");
endmodule // remote_gate_sva
bind remote_input_command_gate remote_gate_sva u_chk (.sys_clk, .rst, .ce,
  .ready, .running, .paused, .error, .emergency_stop_active,
  .guard_open_active, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .start_pulse,
  .program_select_bits, .stop_pulse, .pause_pulse, .continue_pulse,
  .reset_pulse, .remote_mode_active);
`default_nettype wire

// ==== verif/remote_sequencer.sv ====
// Purpose: model of the sequencer that drives the remote lines
// Assumes: lines change right after a rising sys_clk edge
// Notes: a released line sits low, which is its off level
`timescale 1ns/1ps
`default_nettype none
module remote_sequencer (
  // Clock and controller error status
  input wire logic sys_clk,
  input wire logic error,
  // Remote lines
  output logic [23:0] lines
);
  initial lines = '0;
  task automatic hold(input int n, input logic v);
    @(posedge sys_clk);
    lines[n] <= v;
  endtask
  // Rising edge, then off long enough to re-arm
  task automatic press(input int n);
    hold(n, 1'b1);
    repeat (4) @(posedge sys_clk);
    lines[n] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Check error once and, if set, clear it by a reset press
  task automatic clear_error();
    if (error === 1'b1) press(7);
  endtask
endmodule // remote_sequencer
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the remote input command gate
// Assumes: status inputs driven in step with sys_clk
// Notes: action pulses are counted so late or double pulses show
`timescale 1ns/1ps
`default_nettype none
`include "remote_gate_defs.vh"
module testbench;
  logic sys_clk = 0, rst = 1, ce = 1, wr_en = 0, rd_en = 0;
  logic [5:0] st = 6'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [23:0] remote_lines;
  logic [5:0] program_select_bits;
  logic start_pulse, stop_pulse, pause_pulse, continue_pulse, reset_pulse;
  logic shutdown_pulse, forced_low_power, remote_mode_active, irq;
  wire ready = st[0], running = st[1], paused = st[2], error = st[3];
  wire emergency_stop_active = st[4], guard_open_active = st[5];
  int error_cnt = 0, compares = 0;
  int cnt[6] = '{default: 0};
  always #5 sys_clk = ~sys_clk;
  remote_input_command_gate dut (.sys_clk, .rst, .ce, .remote_lines, .ready,
    .running, .paused, .error, .emergency_stop_active, .guard_open_active,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .start_pulse,
    .program_select_bits, .stop_pulse, .pause_pulse, .continue_pulse,
    .reset_pulse, .shutdown_pulse, .forced_low_power, .remote_mode_active,
    .irq);
  remote_sequencer seq (.sys_clk, .error, .lines(remote_lines));
  always @(posedge sys_clk) begin
    cnt[0] += (start_pulse === 1'b1);
    cnt[1] += (stop_pulse === 1'b1);
    cnt[2] += (pause_pulse === 1'b1);
    cnt[3] += (continue_pulse === 1'b1);
    cnt[4] += (reset_pulse === 1'b1);
    cnt[5] += (shutdown_pulse === 1'b1);
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a; wr_data <= v; wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
  endtask
  task automatic set_st(input logic [5:0] v);
    @(posedge sys_clk);
    st <= v;
  endtask
  // Press line n and expect e new pulses of action f
  task automatic act(input int n, input int f, input int e, input string nm);
    int b;
    b = cnt[f];
    seq.press(n);
    chk(nm, e, cnt[f] - b);
  endtask
  task automatic t_regs();
    rdchk("ctrl", `RG_CTRL_ADDR, 32'h0);
    rdchk("map start", 8'h10, 32'h20);
    rdchk("map reset", 8'h20, 32'h27);
    rdchk("map sel4", 8'h34, 32'h23);
    rdchk("map shutdown", 8'h24, 32'h0);
    rdchk("unmapped", 8'hfc, 32'h0);
  endtask
  task automatic t_lowpwr();
    wr(8'h28, 32'h2a);
    seq.hold(10, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk("low power on", 1, forced_low_power);
    seq.hold(10, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk("low power off", 0, forced_low_power);
  endtask
  task automatic t_mode();
    set_st(6'h01);
    act(0, 0, 0, "start without mode");
    wr(`RG_CTRL_ADDR, 32'h3);
    act(0, 0, 0, "start without vio");
    wr(`RG_CTRL_ADDR, 32'h7);
    repeat (3) @(posedge sys_clk);
    chk("mode", 1, remote_mode_active);
  endtask
  task automatic t_start();
    wr(`RG_INT_MASK_ADDR, 32'h1);
    wr(`RG_INT_STAT_ADDR, 32'h7f);
    wr(8'h38, 32'h28);
    seq.hold(1, 1'b1);
    seq.hold(3, 1'b1);
    seq.hold(8, 1'b1);
    act(0, 0, 1, "start");
    chk("program", 6'h0d, program_select_bits);
    chk("irq set", 1, irq);
    wr(`RG_INT_STAT_ADDR, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq clear", 0, irq);
    seq.hold(4, 1'b1);
    act(0, 0, 0, "start with stop");
    seq.hold(4, 1'b0);
    set_st(6'h21);
    act(0, 0, 0, "start with guard");
    rdchk("rejected", `RG_INT_STAT_ADDR, 32'h42);
  endtask
  task automatic t_pause();
    set_st(6'h03);
    act(5, 2, 1, "pause running");
    set_st(6'h01);
    act(5, 2, 0, "pause idle");
    set_st(6'h05);
    act(6, 3, 1, "continue");
    seq.hold(5, 1'b1);
    act(6, 3, 0, "continue with pause");
    seq.hold(5, 1'b0);
  endtask
  task automatic t_error();
    int b;
    set_st(6'h09);
    act(4, 1, 0, "stop in error");
    act(0, 0, 0, "start in error");
    b = cnt[4];
    seq.clear_error();
    chk("reset", 1, cnt[4] - b);
    set_st(6'h01);
    act(4, 1, 1, "stop");
    wr(8'h24, 32'h29);
    act(9, 5, 1, "shutdown");
  endtask
  // Clock enable low freezes the synchroniser, so a press is never seen
  task automatic t_freeze();
    int b;
    b = cnt[1];
    @(posedge sys_clk);
    ce <= 1'b0;
    seq.press(4);
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("stop while frozen", 0, cnt[1] - b);
    act(4, 1, 1, "stop after thaw");
  endtask
  task automatic conclude();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_lowpwr();
    t_mode();
    t_start();
    t_pause();
    t_error();
    t_freeze();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
